// ==== rtl/ssra_pkg.sv ====
// Shared constants, encodings and types of the SMBus sideband register access block.
package ssra_pkg;
    localparam int CLK_MHZ = 200;
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
    localparam int T_LOW_MS = 25;
    localparam int T_HIGH_MS = 50;
    localparam int T_INT_MS = 2;
    localparam int TMR_W = 24;
    localparam logic [TMR_W-1:0] LOW_CYC_DEF = TMR_W'(T_LOW_MS * CYC_PER_MS);
    localparam logic [TMR_W-1:0] HIGH_CYC_DEF = TMR_W'(T_HIGH_MS * CYC_PER_MS);
    localparam logic [TMR_W-1:0] INT_CYC_DEF = TMR_W'(T_INT_MS * CYC_PER_MS);
    localparam logic [TMR_W-1:0] TMR_ONE = 24'h000001;

    // Command byte fields.
    localparam int CMD_BEGIN = 7;
    localparam int CMD_END = 6;
    localparam int CMD_MEM = 5;
    localparam int CMD_PEC = 4;
    localparam int CMD_IC_HI = 3;
    localparam int CMD_IC_LO = 2;
    localparam int CMD_XT_HI = 1;
    localparam int CMD_XT_LO = 0;
    localparam logic [1:0] IC_RD_DW = 2'h0;
    localparam logic [1:0] IC_WR_B = 2'h1;
    localparam logic [1:0] IC_WR_W = 2'h2;
    localparam logic [1:0] IC_WR_DW = 2'h3;
    localparam logic [1:0] XT_BYTE = 2'h0;
    localparam logic [1:0] XT_WORD = 2'h1;
    localparam logic [1:0] XT_BLOCK = 2'h2;

    // Status byte fields.
    localparam int ST_TMO = 7;
    localparam int ST_MA = 5;
    localparam int ST_TA = 4;
    localparam int ST_OK = 0;
    localparam logic [7:0] STATUS_RST = 8'h00;

    // Byte positions inside one SMBus write transaction.
    localparam logic [7:0] IDX_ADDR = 8'h00;
    localparam logic [7:0] IDX_CMD = 8'h01;
    localparam logic [7:0] IDX_D0 = 8'h02;
    localparam logic [7:0] IDX_BD0 = 8'h03;
    localparam logic [7:0] IDX_WLAST = 8'h03;
    localparam logic [7:0] IDX_MAX = 8'hFF;

    // Sequence buffer layout: target, devfn, address high nibble, address low byte, data.
    localparam int BUF_DEPTH = 8;
    localparam logic [3:0] PTR_FULL = 4'h8;
    localparam int B_TGT = 0;
    localparam int B_DEVFN = 1;
    localparam int B_AHI = 2;
    localparam int B_ALO = 3;
    localparam int B_DAT = 4;
    localparam logic [11:0] MASK_DW = 12'hFFC;
    localparam logic [11:0] MASK_W = 12'hFFE;

    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [6:0] SLV_ADDR_DEF = 7'h2A;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam logic [4:0] SYNC_RST = 5'h03;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX = 5'h02,
        ST_ACK = 5'h04,
        ST_EXEC = 5'h08,
        ST_IGN = 5'h10
    } ssra_state_t;

    typedef struct packed {
        logic write;
        logic mem;
        logic [1:0] icmd;
        logic [7:0] target;
        logic [7:0] devfn;
        logic [11:0] addr;
        logic [31:0] data;
    } ssra_req_t;
endpackage

// ==== rtl/ssra_crc8.sv ====
// One-byte update of the SMBus packet error code.
`timescale 1ns/100ps
`default_nettype none
module ssra_crc8
    import ssra_pkg::*;
(
    input wire logic [7:0] crc_in,
    input wire logic [7:0] data_in,
    output logic [7:0] crc_out
);
    always_comb begin
        crc_out = crc_in ^ data_in;
        for (int i = 0; i < 8; i++) begin
            crc_out = crc_out[7] ? ((crc_out << 1) ^ CRC_POLY) : (crc_out << 1);
        end
    end
endmodule
`default_nettype wire

// ==== rtl/ssra_top.sv ====
// SMBus slave that turns write sequences into internal configuration and memory accesses.
//
// Overview of operation
// - Setup bytes gathered from any write type.
// - Register number aligned to internal command width.
// - End-flagged write launches the internal access.
// - Hold SCL low until internal access finishes.
// - Failed internal access NACKs final write byte.
// - Without checking, no checking byte is expected.
// - Unserviced internal access times out, NACK.
// - Internal master or target abort gives NACK.
// - Bad checking byte NACKed, access suppressed.
// - Cumulative SCL low 25 ms resets machine.
// - SCL high 50 ms resets machine.
// - Power-good, hard reset, warm reset reset machine.
// - First requester wins; other waits for completion.
// - SMBus path independent of system queues.
// - Command byte bit layout as defined.
// - Internal command and transfer type encodings.
// - Internal request not done in 2 ms flagged.
`timescale 1ns/100ps
`default_nettype none
module ssra_top
    import ssra_pkg::*;
#(
    parameter logic [6:0] SLV_ADDR = SLV_ADDR_DEF,
    parameter logic [TMR_W-1:0] LOW_CYC = LOW_CYC_DEF,
    parameter logic [TMR_W-1:0] HIGH_CYC = HIGH_CYC_DEF,
    parameter logic [TMR_W-1:0] INT_CYC = INT_CYC_DEF
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic power_good_input,
    input wire logic hard_reset_input_n,
    input wire logic pcie_warm_reset,
    output logic int_req_valid,
    output ssra_req_t int_req,
    input wire logic int_done,
    input wire logic int_master_abort,
    input wire logic int_target_abort,
    input wire logic cpu_req,
    output logic cpu_gnt,
    output logic [7:0] status_byte
);
    logic [4:0] sync1_ff, sync2_ff;
    logic scl_d_ff, sda_d_ff, pin_lo_ff;
    ssra_state_t state_ff, nxt_state;
    logic sda_oe_ff, nxt_sda_oe, scl_oe_ff, nxt_scl_oe, nack_ff, nxt_nack;
    logic have_ff, nxt_have;
    logic [3:0] bit_cnt_ff, nxt_bit_cnt, ptr_ff;
    logic [7:0] idx_ff, nxt_idx, shift_ff, cmd_ff, blk_cnt_ff, crc_ff, status_ff;
    logic [1:0] seq_ic_ff;
    logic seq_err_ff, req_valid_ff, smb_own_ff, cpu_gnt_ff;
    logic [7:0] buf_ff [BUF_DEPTH];
    logic [TMR_W-1:0] low_cnt_ff, high_cnt_ff, exec_cnt_ff;
    ssra_req_t req_ff, req_nxt;
    logic [7:0] crc_upd;

    // Pins and resets from other domains pass two flops before any use.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sync1_ff <= SYNC_RST;
            sync2_ff <= SYNC_RST;
        end else begin
            sync1_ff <= {pcie_warm_reset, hard_reset_input_n, power_good_input, sda_in, scl_in};
            sync2_ff <= sync1_ff;
        end
    end

    wire logic scl_s = sync2_ff[0];
    wire logic sda_s = sync2_ff[1];
    wire logic scl_rise = scl_s & ~scl_d_ff;
    wire logic scl_fall = ~scl_s & scl_d_ff;
    wire logic start_c = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    wire logic stop_c = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    wire logic low_tmo = (low_cnt_ff == LOW_CYC);
    wire logic high_tmo = (high_cnt_ff == HIGH_CYC);
    wire logic int_tmo = (exec_cnt_ff == INT_CYC);
    wire logic ext_rst = ~sync2_ff[2] | ~sync2_ff[3] | sync2_ff[4];
    wire logic sm_rst = ~nrst | ext_rst | low_tmo | high_tmo;

    wire logic in_exec = (state_ff == ST_EXEC);
    wire logic proc = (state_ff == ST_RX) & scl_fall & have_ff;
    wire logic [1:0] xt = cmd_ff[CMD_XT_HI:CMD_XT_LO];
    wire logic [1:0] ic = cmd_ff[CMD_IC_HI:CMD_IC_LO];
    wire logic is_blk = (xt == XT_BLOCK);
    wire logic [7:0] first_data = is_blk ? IDX_BD0 : IDX_D0;
    // The count byte is judged while it is still in the shifter, so a stale count cannot end the frame early.
    wire logic [7:0] blk_len = (idx_ff == IDX_D0) ? shift_ff : blk_cnt_ff;
    wire logic [7:0] last_data = is_blk ? (IDX_D0 + blk_len) : ((xt == XT_WORD) ? IDX_WLAST : IDX_D0);
    wire logic [7:0] final_idx = last_data + {7'h00, cmd_ff[CMD_PEC]};
    wire logic past_cmd = (idx_ff > IDX_CMD);
    wire logic is_final = past_cmd & (idx_ff == final_idx);
    wire logic beyond = past_cmd & (idx_ff > final_idx);
    wire logic is_data = past_cmd & (idx_ff >= first_data) & (idx_ff <= last_data);
    wire logic pec_bad = is_final & cmd_ff[CMD_PEC] & (shift_ff != crc_ff);
    wire logic addr_hit = (shift_ff[7:1] == SLV_ADDR) & ~shift_ff[0];
    wire logic end_bad = is_final & cmd_ff[CMD_END] & seq_err_ff;
    wire logic ack_now = (idx_ff == IDX_ADDR) ? addr_hit : ((idx_ff == IDX_CMD) | ~(beyond | pec_bad | end_bad));
    wire logic go_exec = is_final & cmd_ff[CMD_END] & ~pec_bad & ~seq_err_ff;
    wire logic done_ok = req_valid_ff & int_done;
    // completion or timeout ends the access
    wire logic exec_fin = done_ok | int_tmo;
    wire logic exec_ok = done_ok & ~int_master_abort & ~int_target_abort;
    // a tie goes to SMBus so a stuck processor path cannot block it
    wire logic smb_own_nxt = in_exec & ~exec_fin & (smb_own_ff | ~cpu_gnt_ff);

    ssra_crc8 u_crc (
        .crc_in(crc_ff),
        .data_in(shift_ff),
        .crc_out(crc_upd)
    );

    function automatic logic [11:0] ssra_align(input logic [1:0] icmd, input logic [11:0] a);
        case (icmd)
            IC_WR_B: ssra_align = a;
            IC_WR_W: ssra_align = a & MASK_W;
            default: ssra_align = a & MASK_DW;
        endcase
    endfunction

    assign req_nxt = '{write: (ic != IC_RD_DW), mem: cmd_ff[CMD_MEM], icmd: ic,
                       target: buf_ff[B_TGT], devfn: buf_ff[B_DEVFN],
                       addr: ssra_align(ic, {buf_ff[B_AHI][3:0], buf_ff[B_ALO]}),
                       data: {buf_ff[B_DAT+3], buf_ff[B_DAT+2], buf_ff[B_DAT+1], buf_ff[B_DAT]}};

    always_comb begin
        nxt_state = state_ff;
        nxt_sda_oe = sda_oe_ff;
        nxt_scl_oe = scl_oe_ff;
        nxt_nack = nack_ff;
        nxt_idx = idx_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_have = have_ff;
        case (state_ff)
            ST_IDLE: begin
                nxt_sda_oe = 1'b0;
            end
            ST_RX: begin
                if (scl_rise && !have_ff) begin
                    nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    nxt_have = (bit_cnt_ff == BIT_LAST);
                end else if (proc) begin
                    nxt_have = 1'b0;
                    nxt_bit_cnt = 4'h0;
                    nxt_state = ST_ACK;
                    nxt_sda_oe = ack_now;
                    nxt_nack = ~ack_now;
                    if (go_exec) begin
                        nxt_state = ST_EXEC;
                        nxt_scl_oe = 1'b1;
                        nxt_sda_oe = 1'b0;
                        nxt_nack = 1'b0;
                    end else if (idx_ff == IDX_ADDR && !addr_hit) begin
                        nxt_state = ST_IGN;
                    end
                end
            end
            ST_ACK: begin
                if (scl_fall) begin
                    nxt_sda_oe = 1'b0;
                    nxt_idx = (idx_ff == IDX_MAX) ? idx_ff : idx_ff + 8'h01;
                    nxt_state = nack_ff ? ST_IGN : ST_RX;
                end
            end
            ST_EXEC: begin
                if (exec_fin) begin
                    nxt_scl_oe = 1'b0;
                    nxt_sda_oe = exec_ok;
                    nxt_nack = ~exec_ok;
                    nxt_state = ST_ACK;
                end
            end
            ST_IGN: begin
                nxt_sda_oe = 1'b0;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (stop_c) begin
            nxt_state = ST_IDLE;
            nxt_sda_oe = 1'b0;
        end
        if (start_c) begin
            nxt_state = ST_RX;
            nxt_idx = IDX_ADDR;
            nxt_bit_cnt = 4'h0;
            nxt_have = 1'b0;
            nxt_sda_oe = 1'b0;
        end
        // SCL timeouts and resets return to idle
        if (sm_rst) begin
            nxt_state = ST_IDLE;
            nxt_sda_oe = 1'b0;
            nxt_scl_oe = 1'b0;
            nxt_nack = 1'b0;
            nxt_idx = IDX_ADDR;
            nxt_bit_cnt = 4'h0;
            nxt_have = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
        pin_lo_ff <= 1'b0;
        state_ff <= nxt_state;
        sda_oe_ff <= nxt_sda_oe;
        scl_oe_ff <= nxt_scl_oe;
        nack_ff <= nxt_nack;
        idx_ff <= nxt_idx;
        bit_cnt_ff <= nxt_bit_cnt;
        have_ff <= nxt_have;
    end

    always_ff @(posedge ref_clk) begin
        if (sm_rst) begin
            shift_ff <= 8'h00;
            crc_ff <= CRC_INIT;
        end else if (start_c) begin
            crc_ff <= CRC_INIT;
        end else if (state_ff == ST_RX && scl_rise && !have_ff) begin
            shift_ff <= {shift_ff[6:0], sda_s};
        end else if (proc) begin
            crc_ff <= crc_upd;
        end
    end

    // setup and data bytes fill the sequence buffer
    always_ff @(posedge ref_clk) begin
        if (sm_rst) begin
            cmd_ff <= 8'h00;
            blk_cnt_ff <= 8'h00;
            ptr_ff <= 4'h0;
            seq_ic_ff <= IC_RD_DW;
            seq_err_ff <= 1'b0;
        end else if (proc && idx_ff == IDX_CMD) begin
            cmd_ff <= shift_ff;
            // internal command must stay the same across a sequence
            if (shift_ff[CMD_BEGIN]) begin
                ptr_ff <= 4'h0;
                seq_ic_ff <= shift_ff[CMD_IC_HI:CMD_IC_LO];
                seq_err_ff <= 1'b0;
            end else if (shift_ff[CMD_IC_HI:CMD_IC_LO] != seq_ic_ff) begin
                seq_err_ff <= 1'b1;
            end
        end else if (proc && pec_bad) begin
            seq_err_ff <= 1'b1;
        end else if (proc && is_blk && idx_ff == IDX_D0) begin
            blk_cnt_ff <= shift_ff;
        end else if (proc && is_data && ptr_ff != PTR_FULL) begin
            ptr_ff <= ptr_ff + 4'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (proc && is_data && ptr_ff != PTR_FULL) begin
            buf_ff[ptr_ff[2:0]] <= shift_ff;
        end
    end

    // Our own stretching is excluded, only the master's low time counts.
    always_ff @(posedge ref_clk) begin
        if (sm_rst || start_c || stop_c || state_ff == ST_IDLE) begin
            low_cnt_ff <= '0;
        end else if (!scl_s && !scl_oe_ff) begin
            low_cnt_ff <= low_cnt_ff + TMR_ONE;
        end
        if (sm_rst || !scl_s) begin
            high_cnt_ff <= '0;
        end else begin
            high_cnt_ff <= high_cnt_ff + TMR_ONE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sm_rst || !in_exec || exec_fin) begin
            exec_cnt_ff <= '0;
        end else begin
            exec_cnt_ff <= exec_cnt_ff + TMR_ONE;
        end
        if (!nrst || ext_rst) begin
            status_ff <= STATUS_RST;
        end else if (in_exec && exec_fin) begin
            status_ff <= STATUS_RST;
            status_ff[ST_TMO] <= ~done_ok;
            status_ff[ST_MA] <= done_ok & int_master_abort;
            status_ff[ST_TA] <= done_ok & int_target_abort;
            status_ff[ST_OK] <= exec_ok;
        end
    end

    // first requester keeps the unit until done
    always_ff @(posedge ref_clk) begin
        if (sm_rst) begin
            smb_own_ff <= 1'b0;
            req_valid_ff <= 1'b0;
        end else begin
            smb_own_ff <= smb_own_nxt;
            req_valid_ff <= smb_own_nxt & smb_own_ff;
        end
        // SCL timeouts belong to the SMBus side and must not take the unit from the processor.
        if (!nrst) begin
            cpu_gnt_ff <= 1'b0;
        end else begin
            cpu_gnt_ff <= cpu_req & ~smb_own_nxt;
        end
        if (in_exec && !req_valid_ff) begin
            req_ff <= req_nxt;
        end
    end

    assign scl_out = pin_lo_ff;
    assign sda_out = pin_lo_ff;
    assign scl_oe = scl_oe_ff;
    assign sda_oe = sda_oe_ff;
    assign int_req_valid = req_valid_ff;
    assign int_req = req_ff;
    assign cpu_gnt = cpu_gnt_ff;
    assign status_byte = status_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_launch_end: assert property ($rose(req_valid_ff) |-> cmd_ff[CMD_END] && scl_oe_ff && in_exec)
        else $error("internal access launched without end flag");
    a_stretch_hold: assert property (req_valid_ff && !int_done && !int_tmo && !sm_rst |=> scl_oe_ff)
        else $error("SCL released while internal access pending");
    a_addr_align: assert property (req_valid_ff && req_ff.icmd == IC_WR_DW |-> req_ff.addr[1:0] == 2'h0)
        else $error("doubleword address not aligned");
    a_abort_nack: assert property (in_exec && done_ok && (int_master_abort || int_target_abort) && !sm_rst
        |=> state_ff == ST_ACK && !sda_oe_ff && nack_ff && !scl_oe_ff)
        else $error("abort not answered by NACK");
    a_tmo_nack: assert property (in_exec && int_tmo && !done_ok && !sm_rst
        |=> status_ff[ST_TMO] && !sda_oe_ff && !req_valid_ff)
        else $error("internal timeout not reported");
    a_tmo_bound: assert property (in_exec |-> exec_cnt_ff <= INT_CYC)
        else $error("internal timer passed its limit");
    a_pec_nack: assert property (proc && pec_bad && !sm_rst && !start_c && !stop_c
        |=> (!sda_oe_ff && nack_ff && !req_valid_ff && !in_exec)[*2])
        else $error("bad checking byte not refused");
    a_low_reset: assert property (low_tmo |=> state_ff == ST_IDLE && !scl_oe_ff)
        else $error("cumulative low timeout ignored");
    a_high_reset: assert property (high_tmo |=> state_ff == ST_IDLE && low_cnt_ff == '0)
        else $error("high timeout ignored");
    a_ext_reset: assert property (ext_rst |=> state_ff == ST_IDLE && !req_valid_ff && !sda_oe_ff)
        else $error("external reset ignored");
    a_arb_mutex: assert property (!(cpu_gnt_ff && smb_own_ff))
        else $error("both requesters own the unit");
    a_cpu_keeps: assert property (cpu_gnt_ff && cpu_req && !sm_rst |=> cpu_gnt_ff && !req_valid_ff)
        else $error("processor lost the unit mid access");

    c_write_ok: cover property (in_exec && exec_ok ##1 state_ff == ST_ACK && sda_oe_ff);
    c_pec_bad: cover property (proc && pec_bad);
    c_int_tmo: cover property (in_exec && int_tmo);
    c_cpu_stall: cover property (in_exec && cpu_gnt_ff ##[1:50] req_valid_ff);
endmodule
`default_nettype wire

// ==== sim/ssra_master_model.sv ====
// Behavioural SMBus master that clocks the slave and reads back its acknowledges.
`timescale 1ns/100ps
`default_nettype none
module ssra_master_model
    import ssra_pkg::*;
(
    input wire logic ref_clk,
    input wire logic scl_oe,
    input wire logic sda_oe,
    output logic scl_in,
    output logic sda_in,
    output logic hung
);
    logic scl_lo = 1'h0;
    logic sda_lo = 1'h0;
    initial hung = 1'h0;
    // Both lines are pulled up, so a released line reads high.
    assign scl_in = ~(scl_lo | scl_oe);
    assign sda_in = ~(sda_lo | sda_oe);

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // A stretching slave may keep SCL low; the wait is bounded so a stuck slave ends the run.
    task automatic clk_hi();
        int i;
        scl_lo <= 1'h0;
        tick(1);
        for (i = 0; i < 5000 && scl_in !== 1'h1; i++) tick(1);
        if (scl_in !== 1'h1) hung <= 1'h1;
    endtask

    task automatic wbit(input logic b, output logic s);
        sda_lo <= ~b;
        tick(4);
        clk_hi();
        tick(3);
        s = sda_in;
        tick(4);
        scl_lo <= 1'h1;
        tick(4);
    endtask

    task automatic wbyte(input logic [7:0] d, output logic a);
        int i;
        logic s;
        for (i = 7; i >= 0; i--) wbit(d[i], s);
        wbit(1'h1, s);
        a = ~s;
    endtask

    task automatic start();
        sda_lo <= 1'h1;
        tick(8);
        scl_lo <= 1'h1;
        tick(4);
    endtask

    task automatic stop();
        sda_lo <= 1'h1;
        tick(4);
        clk_hi();
        tick(4);
        sda_lo <= 1'h0;
        tick(16);
    endtask

    // Leaves SCL high for n cycles in mid-frame, then takes it low again.
    task automatic idle_hi(input int n);
        scl_lo <= 1'h0;
        tick(n);
        scl_lo <= 1'h1;
        tick(4);
    endtask
endmodule
`default_nettype wire

// ==== sim/ssra_top_tb.sv ====
// Self-checking bench for the SMBus sideband register access block.
`timescale 1ns/100ps
`default_nettype none
module ssra_top_tb
    import ssra_pkg::*;
;
    logic ref_clk = 1'h0;
    logic nrst = 1'h0;
    logic power_good_input = 1'h1;
    logic hard_reset_input_n = 1'h1;
    logic pcie_warm_reset = 1'h0;
    logic int_done = 1'h0;
    logic rsp_ma = 1'h0;
    logic rsp_ta = 1'h0;
    logic rsp_hang = 1'h0;
    logic cpu_req = 1'h0;
    logic scl_in, sda_in, scl_oe, sda_oe, scl_out, sda_out, int_req_valid, cpu_gnt, hung, ack;
    logic [7:0] status_byte;
    ssra_req_t int_req, got;
    int rsp_dly = 5;
    int wcnt = 0;
    int launches = 0;
    int fails = 0;
    int check_count = 0;

    always #2.5 ref_clk = ~ref_clk;

    ssra_top #(.LOW_CYC(24'h000FA0), .HIGH_CYC(24'h001F40), .INT_CYC(24'h0000C8)) DUT (
        .ref_clk(ref_clk), .nrst(nrst), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .power_good_input(power_good_input),
        .hard_reset_input_n(hard_reset_input_n), .pcie_warm_reset(pcie_warm_reset),
        .int_req_valid(int_req_valid), .int_req(int_req), .int_done(int_done),
        .int_master_abort(rsp_ma), .int_target_abort(rsp_ta), .cpu_req(cpu_req),
        .cpu_gnt(cpu_gnt), .status_byte(status_byte));

    ssra_master_model m (.ref_clk(ref_clk), .scl_oe(scl_oe), .sda_oe(sda_oe),
        .scl_in(scl_in), .sda_in(sda_in), .hung(hung));

    // Internal unit: answers after rsp_dly cycles unless told to hang.
    always @(posedge ref_clk) begin
        int_done <= 1'h0;
        wcnt <= 0;
        if (int_req_valid === 1'h1 && int_done !== 1'h1) begin
            if (wcnt == 0) got <= int_req;
            if (wcnt == 0) launches <= launches + 1;
            wcnt <= wcnt + 1;
            if (wcnt == rsp_dly && !rsp_hang) int_done <= 1'h1;
        end
    end

    always @(posedge hung) begin
        fails++;
        summarize();
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [65:0] e, input logic [65:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic wt(input logic v);
        int i;
        for (i = 0; i < 10000; i++) begin
            if ((v ? int_req_valid : scl_oe) === 1'h1) return;
            tick(1);
        end
        fails++;
        summarize();
    endtask

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        int i;
        c = c ^ b;
        for (i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'h0} ^ 8'h07 : {c[6:0], 1'h0};
        return c;
    endfunction

    task automatic xact(input logic [7:0] cmd, input logic [31:0] d, input int n, input logic bad);
        logic [7:0] c;
        int i;
        c = crc8(crc8(8'h00, 8'h54), cmd);
        m.start();
        m.wbyte(8'h54, ack);
        m.wbyte(cmd, ack);
        if (cmd[1:0] == 2'h2) m.wbyte(8'(n), ack);
        if (cmd[1:0] == 2'h2) c = crc8(c, 8'(n));
        for (i = 0; i < n; i++) m.wbyte(d[8*i+:8], ack);
        for (i = 0; i < n; i++) c = crc8(c, d[8*i+:8]);
        if (cmd[4]) m.wbyte(c ^ {7'h00, bad}, ack);
        m.stop();
    endtask

    // Setup by byte, block and word writes, then the final word write carries the end flag.
    task automatic seq(input logic [1:0] ia, input logic [1:0] ib, input logic p, input logic bad);
        logic [7:0] c;
        c = {2'h0, ia[0], p, ia, 2'h0};
        xact(c | 8'h80, 32'h0000005A, 1, 1'h0);
        xact(c | 8'h02, 32'h0057A3C3, 3, 1'h0);
        xact(c | 8'h01, 32'h0000CDEF, 2, 1'h0);
        xact({2'h1, ib[0], p, ib, 2'h1}, 32'h000089AB, 2, bad);
    endtask

    task automatic align_scn();
        int k;
        logic [1:0] ic;
        ssra_req_t e;
        for (k = 0; k < 4; k++) begin
            ic = 2'(k);
            seq(ic, ic, 1'h0, 1'h0);
            e = '{1'(ic != 2'h0), ic[0], ic, 8'h5A, 8'hC3,
                12'h357 & (ic == 2'h1 ? 12'hFFF : ic == 2'h2 ? 12'hFFE : 12'hFFC), 32'h89ABCDEF};
            chk("ack", 1'h1, ack);
            chk("pin_out", 2'h0, {scl_out, sda_out});
            chk("int_req", e, got);
            chk("status_byte", 8'h01, status_byte);
        end
    endtask

    task automatic err_scn();
        int k;
        for (k = 0; k < 4; k++) begin
            rsp_ma <= (k == 0);
            rsp_ta <= (k == 1);
            rsp_hang <= (k == 2);
            seq(2'h3, 2'h3, 1'h0, 1'h0);
            chk("ack", 1'(k == 3), ack);
            chk("status_byte", k == 0 ? 8'h20 : k == 1 ? 8'h10 : k == 2 ? 8'h80 : 8'h01, status_byte);
        end
    endtask

    task automatic pec_scn();
        int n;
        seq(2'h3, 2'h3, 1'h1, 1'h0);
        chk("ack", 1'h1, ack);
        n = launches;
        seq(2'h3, 2'h3, 1'h1, 1'h1);
        chk("ack", 1'h0, ack);
        seq(2'h3, 2'h1, 1'h0, 1'h0);
        chk("ack", 1'h0, ack);
        chk("launches", 66'(n), 66'(launches));
    endtask

    task automatic arb_scn();
        cpu_req <= 1'h1;
        tick(3);
        chk("cpu_gnt", 1'h1, cpu_gnt);
        fork
            seq(2'h3, 2'h3, 1'h0, 1'h0);
            begin
                wt(1'h0);
                tick(40);
                chk("int_req_valid", 1'h0, int_req_valid);
                cpu_req <= 1'h0;
            end
        join
        chk("ack", 1'h1, ack);
        rsp_dly = 60;
        fork
            seq(2'h3, 2'h3, 1'h0, 1'h0);
            begin
                wt(1'h1);
                cpu_req <= 1'h1;
                tick(5);
                chk("cpu_gnt", 1'h0, cpu_gnt);
            end
        join
        cpu_req <= 1'h0;
        rsp_dly = 5;
        tick(3);
    endtask

    task automatic tmo_scn();
        m.start();
        m.wbyte(8'h54, ack);
        m.wbyte(8'h8C, ack);
        tick(4100);
        m.wbyte(8'h5A, ack);
        chk("ack", 1'h0, ack);
        m.stop();
        m.start();
        m.wbyte(8'h54, ack);
        m.wbyte(8'h8C, ack);
        m.idle_hi(8100);
        m.wbyte(8'h5A, ack);
        chk("ack", 1'h0, ack);
        m.stop();
    endtask

    task automatic rst_scn();
        int k;
        for (k = 0; k < 3; k++) begin
            seq(2'h3, 2'h3, 1'h0, 1'h0);
            m.start();
            m.wbyte(8'h54, ack);
            power_good_input <= (k != 0);
            hard_reset_input_n <= (k != 1);
            pcie_warm_reset <= (k == 2);
            tick(4);
            power_good_input <= 1'h1;
            hard_reset_input_n <= 1'h1;
            pcie_warm_reset <= 1'h0;
            tick(6);
            chk("status_byte", 8'h00, status_byte);
            m.wbyte(8'h8C, ack);
            chk("ack", 1'h0, ack);
            m.stop();
        end
    endtask

    initial begin
        tick(4);
        nrst <= 1'h1;
        tick(8);
        align_scn();
        err_scn();
        pec_scn();
        arb_scn();
        tmo_scn();
        rst_scn();
        summarize();
    end
endmodule
`default_nettype wire
